// *** hdl/ligc_pkg.sv ***
// Package for the line interface global control register block.
// Assumes one 20 MHz system clock and an 8-bit processor write/read port.
package ligc_pkg;
    localparam int LIGC_CHANNELS = 8;
    localparam logic [7:0] LIGC_CTRL0_RESET = 8'h00;
    localparam logic [7:0] LIGC_CTRL0_WMASK = 8'h7B;
    localparam int LIGC_BIT_ALLONES = 6;
    localparam int LIGC_BIT_RXEDGE = 5;
    localparam int LIGC_BIT_TXEDGE = 4;
    localparam int LIGC_BIT_POLARITY = 3;
    localparam int LIGC_BIT_GIE = 1;
    localparam int LIGC_BIT_SOFTWARE_DEVICE_RESET = 0;
    localparam int LIGC_CLK_HZ = 20000000;
    localparam int LIGC_SOFTWARE_DEVICE_RESET_HOLD_NS = 10000;
    // Strictly longer than the hold: floor of cycles, plus one
    localparam int LIGC_SOFTWARE_DEVICE_RESET_HOLD_CYC =
        (LIGC_SOFTWARE_DEVICE_RESET_HOLD_NS / (1000000000 / LIGC_CLK_HZ)) + 1;
    localparam int LIGC_SOFTWARE_DEVICE_RESET_PULSE_CYC = 4;
    localparam int LIGC_CNT_W = 9;
endpackage

// *** hdl/ligc_global_control.sv ***
// Global control register of an eight-channel line interface unit.
// Assumes wrEn/rdEn are single-cycle strobes synchronous to sys_clk and
// that channel status, enables and line clock come from outside the domain.
//
// Contract
// [R1] With all-ones enabled, a channel losing signal sends all ones.
// [R2] The receive edge bit picks rising (0) or falling (1) rail update.
// [R3] The transmit edge bit picks falling (0) or rising (1) rail sampling.
// [R4] The polarity bit inverts transmit inputs and receive outputs.
// [R5] With global enable clear no interrupt reaches the pin.
// [R6] The pin asserts only for sources enabled at both levels.
// [R7] The reset bit must stay one longer than 10 us before reset starts.
// [R8] Software reset clears internal circuits but not register bits.
// [R9] Interrupt is global enable AND the OR of status AND enable.
`timescale 1ns/1ps
module ligc_global_control
    import ligc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    input wire logic [7:0] receive_signal_loss,
    input wire logic [7:0] sourceStatus,
    input wire logic [7:0] sourceEnable,
    input wire logic transmit_line_clock,
    input wire logic [7:0] transmit_positive_rail,
    input wire logic [7:0] transmit_negative_rail,
    input wire logic [7:0] recoveredPos,
    input wire logic [7:0] recoveredNeg,
    input wire logic [7:0] framerTxData,
    output logic [7:0] receive_positive_rail,
    output logic [7:0] receive_negative_rail,
    output logic [7:0] txSamplePos,
    output logic [7:0] txSampleNeg,
    output logic [7:0] framerLineData,
    output logic intr_n,
    output logic internalReset
);
    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    logic [7:0] line_interface_global_control_0;
    logic auto_all_ones_on_signal_loss;
    logic receive_output_edge_select;
    logic transmit_sample_edge_select;
    logic data_polarity_select;
    logic global_interrupt_enable;
    logic software_device_reset;

    assign auto_all_ones_on_signal_loss =
        line_interface_global_control_0[LIGC_BIT_ALLONES];
    assign receive_output_edge_select =
        line_interface_global_control_0[LIGC_BIT_RXEDGE];
    assign transmit_sample_edge_select =
        line_interface_global_control_0[LIGC_BIT_TXEDGE];
    assign data_polarity_select =
        line_interface_global_control_0[LIGC_BIT_POLARITY];
    assign global_interrupt_enable =
        line_interface_global_control_0[LIGC_BIT_GIE];
    assign software_device_reset =
        line_interface_global_control_0[LIGC_BIT_SOFTWARE_DEVICE_RESET];

    // [R8] Register untouched by soft reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_interface_global_control_0 <= LIGC_CTRL0_RESET;
        end else if (wrEn) begin
            line_interface_global_control_0 <= wrData & LIGC_CTRL0_WMASK;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            rdData <= line_interface_global_control_0;
        end
    end

    // ------------------------------------------------------------
    // Software reset hold timer
    // ------------------------------------------------------------
    logic [LIGC_CNT_W-1:0] holdCount;
    logic [2:0] pulseCount;
    logic holdDone;

    // [R7] Hold must exceed 10 us
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            holdCount <= '0;
            holdDone <= 1'b0;
        end else if (!software_device_reset) begin
            holdCount <= '0;
            holdDone <= 1'b0;
        end else if (holdCount != LIGC_CNT_W'(LIGC_SOFTWARE_DEVICE_RESET_HOLD_CYC)) begin
            holdCount <= holdCount + LIGC_CNT_W'(1);
        end else begin
            holdDone <= 1'b1;
        end
    end

    // Fires once per hold; pulse stretched so slow logic sees it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseCount <= 3'h0;
        end else if (software_device_reset && !holdDone
                     && holdCount == LIGC_CNT_W'(LIGC_SOFTWARE_DEVICE_RESET_HOLD_CYC)) begin
            pulseCount <= 3'(LIGC_SOFTWARE_DEVICE_RESET_PULSE_CYC);
        end else if (pulseCount != 3'h0) begin
            pulseCount <= pulseCount - 3'h1;
        end
    end

    // [R8] Internal reset from timer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            internalReset <= 1'b0;
        end else begin
            internalReset <= (pulseCount != 3'h0);
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [7:0] losMeta, losSync, statMeta, statSync, enMeta, enSync;
    logic [7:0] tpMeta, tpSync, tnMeta, tnSync;
    logic [7:0] rpMeta, rpSync, rnMeta, rnSync;
    logic clkMeta, clkSync, clkPrev;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {losMeta, losSync, statMeta, statSync} <= '0;
            {enMeta, enSync, tpMeta, tpSync, tnMeta, tnSync} <= '0;
            {rpMeta, rpSync, rnMeta, rnSync} <= '0;
            {clkMeta, clkSync, clkPrev} <= 3'h0;
        end else begin
            losMeta <= receive_signal_loss;
            losSync <= losMeta;
            statMeta <= sourceStatus;
            statSync <= statMeta;
            enMeta <= sourceEnable;
            enSync <= enMeta;
            tpMeta <= transmit_positive_rail;
            tpSync <= tpMeta;
            tnMeta <= transmit_negative_rail;
            tnSync <= tnMeta;
            rpMeta <= recoveredPos;
            rpSync <= rpMeta;
            rnMeta <= recoveredNeg;
            rnSync <= rnMeta;
            clkMeta <= transmit_line_clock;
            clkSync <= clkMeta;
            clkPrev <= clkSync;
        end
    end

    logic clkRise, clkFall, txStrobe, rxStrobe;
    assign clkRise = clkSync && !clkPrev;
    assign clkFall = !clkSync && clkPrev;
    // [R3] Transmit sample edge
    assign txStrobe = transmit_sample_edge_select ? clkRise : clkFall;
    // [R2] Receive update edge
    assign rxStrobe = receive_output_edge_select ? clkFall : clkRise;

    // ------------------------------------------------------------
    // Data paths
    // ------------------------------------------------------------
    // [R4] Polarity on transmit sampling
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            txSamplePos <= 8'h00;
            txSampleNeg <= 8'h00;
        end else if (internalReset) begin
            txSamplePos <= 8'h00;
            txSampleNeg <= 8'h00;
        end else if (txStrobe) begin
            txSamplePos <= tpSync ^ {8{data_polarity_select}};
            txSampleNeg <= tnSync ^ {8{data_polarity_select}};
        end
    end

    // [R4] Polarity on receive outputs
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_positive_rail <= 8'h00;
            receive_negative_rail <= 8'h00;
        end else if (internalReset) begin
            receive_positive_rail <= 8'h00;
            receive_negative_rail <= 8'h00;
        end else if (rxStrobe) begin
            receive_positive_rail <= rpSync ^ {8{data_polarity_select}};
            receive_negative_rail <= rnSync ^ {8{data_polarity_select}};
        end
    end

    // [R1] All ones on signal loss
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            framerLineData <= 8'h00;
        end else if (internalReset) begin
            framerLineData <= 8'h00;
        end else begin
            framerLineData <= auto_all_ones_on_signal_loss
                ? (framerTxData | losSync) : framerTxData;
        end
    end

    // [R5] [R6] [R9] Two-level interrupt gating
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            intr_n <= 1'b1;
        end else if (internalReset) begin
            intr_n <= 1'b1;
        end else begin
            intr_n <= !(global_interrupt_enable && |(statSync & enSync));
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_hold_complete;
        software_device_reset && holdCount ==
            LIGC_CNT_W'(LIGC_SOFTWARE_DEVICE_RESET_HOLD_CYC) && !holdDone;
    endsequence

    a_gie_blocks_irq: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!reset_n)
        !global_interrupt_enable |=> intr_n)
        else $error("Interrupt with global enable clear");
    a_irq_both_levels: assert property ( // [R6]
        @(posedge sys_clk) disable iff (!reset_n)
        !intr_n |-> $past(global_interrupt_enable && |(statSync & enSync)))
        else $error("Interrupt without source enabled at both levels");
    a_irq_and_or: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!reset_n)
        (!internalReset && global_interrupt_enable
         && |(statSync & enSync)) |=> !intr_n || internalReset)
        else $error("Enabled source failed to raise interrupt");
    a_reset_after_hold: assert property ( // [R7]
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(internalReset) |-> $past(software_device_reset, 2)
        && $past(holdCount, 2) == LIGC_CNT_W'(LIGC_SOFTWARE_DEVICE_RESET_HOLD_CYC))
        else $error("Soft reset began before hold elapsed");
    a_hold_fires: assert property ( // [R7]
        @(posedge sys_clk) disable iff (!reset_n)
        s_hold_complete |=> ##1 internalReset [*4])
        else $error("Soft reset pulse missing after hold");
    a_reg_kept: assert property ( // [R8]
        @(posedge sys_clk) disable iff (!reset_n)
        (internalReset && !wrEn) |=> $stable(line_interface_global_control_0))
        else $error("Soft reset disturbed register");
    a_all_ones: assert property ( // [R1]
        @(posedge sys_clk) disable iff (!reset_n)
        (auto_all_ones_on_signal_loss && !internalReset) |=>
            ((framerLineData & $past(losSync)) == $past(losSync))
            || internalReset)
        else $error("All ones missing on signal loss");
    a_tx_edge: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!reset_n)
        (!internalReset && transmit_sample_edge_select && clkFall
         && !clkRise) |=> $stable(txSamplePos) || internalReset)
        else $error("Transmit sampled on wrong edge");
    a_rx_polarity: assert property ( // [R4]
        @(posedge sys_clk) disable iff (!reset_n)
        (!internalReset && rxStrobe) |=> internalReset
        || receive_positive_rail == ($past(rpSync)
            ^ {8{$past(data_polarity_select)}}))
        else $error("Receive polarity wrong");
    a_rx_edge: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!reset_n)
        (!internalReset && !receive_output_edge_select && clkFall)
        |=> $stable(receive_positive_rail) || internalReset)
        else $error("Receive updated on wrong edge");
endmodule

// *** verif/ligc_global_control_tb.sv ***
// Self-checking bench for the global control register block.
// Assumes the block alone, driven at the falling edge of a 20 MHz clock.
`timescale 1ns/1ps
module ligc_global_control_tb
    import ligc_pkg::*;
;
    logic sysClk = 1'b0, resetN = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
    logic lineClk = 1'b0;
    logic [7:0] wrData = 8'h00, loss = 8'h00, stat = 8'h00, ena = 8'h00;
    logic [7:0] txPos = 8'h00, txNeg = 8'h00, recPos = 8'h00;
    logic [7:0] recNeg = 8'h00, framerTx = 8'h00;
    logic [7:0] rdData, rxPos, rxNeg, smpPos, smpNeg, lineData;
    logic intrN, intReset;
    int badCount = 0, checked = 0, srCount = 0;

    always #25 sysClk = ~sysClk;
    // Counted on the falling edge, away from the launching edge, so the pulse is settled
    always @(negedge sysClk) begin
        if (intReset === 1'b1) begin
            srCount++;
        end
    end

    ligc_global_control uut (.sys_clk(sysClk), .reset_n(resetN),
        .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData),
        .receive_signal_loss(loss), .sourceStatus(stat),
        .sourceEnable(ena), .transmit_line_clock(lineClk),
        .transmit_positive_rail(txPos), .transmit_negative_rail(txNeg),
        .recoveredPos(recPos), .recoveredNeg(recNeg),
        .framerTxData(framerTx), .receive_positive_rail(rxPos),
        .receive_negative_rail(rxNeg), .txSamplePos(smpPos),
        .txSampleNeg(smpNeg), .framerLineData(lineData),
        .intr_n(intrN), .internalReset(intReset));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, exp, input string msg);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("CHECK FAILED t=%0t %s: %h vs %h", $time, msg, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sysClk);
    endtask

    task automatic wr(input logic [7:0] d);
        wrData = d;
        wrEn = 1'b1;
        cyc(1);
        wrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] exp);
        rdEn = 1'b1;
        cyc(1);
        rdEn = 1'b0;
        cyc(1);
        check(rdData, exp, "register read");
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_mask();
        check({7'h00, intrN}, 8'h01, "intr idle");
        rd(LIGC_CTRL0_RESET);
        wr(8'hFE);
        rd(8'h7A);
        wr(8'h00);
        rd(8'h00);
        $display("test reset_and_mask done");
    endtask

    // Rising half updates with data A, falling half with data B
    task automatic t_edge(input logic [7:0] ctrl);
        logic [7:0] a, b, p;
        a = 8'h3C;
        b = 8'hA5;
        p = ctrl[3] ? 8'hFF : 8'h00;
        wr(ctrl);
        recPos = a;
        recNeg = ~a;
        txPos = a;
        txNeg = ~a;
        cyc(4);
        // Line clock half period of 200 ns; data moves mid-high
        lineClk = 1'b1;
        cyc(2);
        recPos = b;
        recNeg = ~b;
        txPos = b;
        txNeg = ~b;
        cyc(2);
        lineClk = 1'b0;
        cyc(5);
        check(rxPos, (ctrl[5] ? b : a) ^ p, "rx pos rail");
        check(rxNeg, ~(ctrl[5] ? b : a) ^ p, "rx neg rail");
        check(smpPos, (ctrl[4] ? a : b) ^ p, "tx pos sample");
        check(smpNeg, ~(ctrl[4] ? a : b) ^ p, "tx neg sample");
        $display("test edge ctrl=%h done", ctrl);
    endtask

    task automatic t_intr(input logic [7:0] ctrl, s, e, input logic exp);
        stat = s;
        ena = e;
        wr(ctrl);
        cyc(5);
        check({7'h00, intrN}, {7'h00, exp}, "intr pin");
        $display("test intr ctrl=%h st=%h en=%h done", ctrl, s, e);
    endtask

    task automatic t_all_ones();
        loss = 8'h81;
        framerTx = 8'h06;
        wr(8'h40);
        cyc(4);
        check(lineData, 8'h87, "all ones on loss");
        wr(8'h00);
        cyc(4);
        check(lineData, 8'h06, "all ones off");
        $display("test all_ones done");
    endtask

    task automatic t_soft_reset();
        int n;
        srCount = 0;
        wr(8'h01);
        cyc(150);
        wr(8'h00);
        cyc(20);
        check(srCount[7:0], 8'h00, "short hold no reset");
        stat = 8'h01;
        ena = 8'h01;
        loss = 8'h01;
        wr(8'h43);
        n = 0;
        while (intReset !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        // Pulse starts two cycles after the hold count completes
        check({7'h00, n == LIGC_SOFTWARE_DEVICE_RESET_HOLD_CYC + 2}, 8'h01, "hold");
        // Outputs are cleared one cycle after the pulse rises
        cyc(1);
        check({7'h00, intrN}, 8'h01, "intr off in reset");
        check(lineData, 8'h00, "path off in reset");
        cyc(20);
        check(srCount[7:0], 8'(LIGC_SOFTWARE_DEVICE_RESET_PULSE_CYC), "one pulse");
        rd(8'h43);
        $display("test soft_reset done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        cyc(10);
        resetN = 1'b1;
        cyc(1);
        t_reset_and_mask();
        t_edge(8'h00);
        t_edge(8'h20);
        t_edge(8'h10);
        t_edge(8'h08);
        t_edge(8'h38);
        t_intr(8'h00, 8'hFF, 8'hFF, 1'b1);
        t_intr(8'h02, 8'h0F, 8'hF0, 1'b1);
        t_intr(8'h02, 8'h10, 8'h10, 1'b0);
        t_intr(8'h02, 8'h80, 8'h80, 1'b0);
        t_intr(8'h00, 8'h80, 8'h80, 1'b1);
        t_all_ones();
        t_soft_reset();
        report_and_stop();
    end

    // Whole run is under 2000 cycles; allow ample margin
    initial begin
        cyc(20000);
        badCount++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
